// ### rtl/kxc_codec.sv
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module kxc_codec #(
   parameter int TIMER_CYC = kxc_pkg::REPLY_WAIT_CYC
) (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // received message bytes
   input  wire logic                        rx_valid,
   input  wire logic [7:0]                  rx_data,
   input  wire logic                        rx_last,
   output logic                             rx_ready,
   // transmitted message bytes
   output logic                             tx_valid,
   output logic [7:0]                       tx_data,
   output logic                             tx_last,
   input  wire logic                        tx_ready,
   // keyed hash engine
   output logic                             mac_req,
   output logic [7:0]                       mac_key_slot,
   output logic [kxc_pkg::FRAME_W-1:0]      mac_msg,
   output logic [kxc_pkg::LEN_W-1:0]        mac_len,
   input  wire logic                        mac_done,
   input  wire logic [kxc_pkg::TAG_W-1:0]   mac_tag
);
   typedef struct packed {
      kxc_pkg::kxc_state_t              st;
      logic [4:0]                       rx_cnt;
      logic [7:0]                       rx_type;
      logic [7:0]                       rx_b1;
      logic [7:0]                       rx_b2;
      logic [7:0]                       offer_txn;
      logic [7:0]                       offer_slot;
      logic [7:0]                       active;
      logic [7:0]                       pending;
      logic [7:0]                       last_good;
      logic [7:0]                       outcome;
      logic [7:0]                       wanted;
      logic                             ask_pend;
      logic [kxc_pkg::ST_W-1:0]         sticky;
      logic [kxc_pkg::TMR_W-1:0]        tmr;
      logic                             tmr_run;
      logic [kxc_pkg::FRAME_W-1:0]      frame;
      logic [kxc_pkg::LEN_W-1:0]        len;
      logic                             mac_req;
      logic [31:0]                      prdata;
      logic                             pslverr;
   } kxc_codec_t;

   kxc_codec_t s_ff;
   kxc_codec_t nxt_s;

   logic       ser_busy;
   logic       rx_take;
   logic       apb_setup;
   logic       apb_wr;
   logic [7:0] v_type;
   logic [7:0] v_b1;
   logic [7:0] v_b2;
   logic [7:0] oc;
   logic       tag_on;
   logic       prior_on;
   logic [kxc_pkg::ST_W-1:0] set_bits;
   logic [kxc_pkg::ST_W-1:0] clr_bits;

   assign rx_ready  = (s_ff.st == kxc_pkg::KXC_IDLE) && !ser_busy;
   assign rx_take   = rx_valid && rx_ready;
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;

   // message header bytes seen so far, including this one
   always_comb begin
      v_type = (s_ff.rx_cnt == 5'h00) ? rx_data : s_ff.rx_type;
      v_b1   = (s_ff.rx_cnt == 5'h01) ? rx_data : s_ff.rx_b1;
      v_b2   = (s_ff.rx_cnt == 5'h02) ? rx_data : s_ff.rx_b2;
   end

   // outcome for the terminal done message
   always_comb begin
      oc       = (v_b1 != s_ff.offer_txn) ? kxc_pkg::OC_BAD_TXN : s_ff.outcome;
      tag_on   = !((oc == kxc_pkg::OC_MIC_FAIL) || (oc == kxc_pkg::OC_NO_MK));
      // prior tag only for bad txn
      prior_on = (oc == kxc_pkg::OC_BAD_TXN);
   end

   always_comb begin
      nxt_s         = s_ff;
      nxt_s.mac_req = 1'b0;
      set_bits      = '0;
      clr_bits      = '0;

      // apb read data captured in the setup phase
      if (apb_setup) begin
         nxt_s.pslverr = 1'b0;
         nxt_s.prdata  = 32'h0000_0000;
         case (paddr)
            kxc_pkg::REG_CTRL: begin
               nxt_s.prdata[kxc_pkg::CTRL_WANT_LSB +: 8] = s_ff.wanted;
               nxt_s.prdata[kxc_pkg::CTRL_ASK_BIT]       = s_ff.ask_pend;
            end

            kxc_pkg::REG_OUTCOME: begin
               nxt_s.prdata[7:0] = s_ff.outcome;
            end

            kxc_pkg::REG_KEYSLOT: begin
               nxt_s.prdata[7:0]                    = s_ff.active;
               nxt_s.prdata[kxc_pkg::PEND_LSB +: 8] = s_ff.pending;
            end

            kxc_pkg::REG_LAST_GOOD: begin
               nxt_s.prdata[7:0] = s_ff.last_good;
            end

            kxc_pkg::REG_STATUS: begin
               nxt_s.prdata[kxc_pkg::ST_W-1:0]             = s_ff.sticky;
               nxt_s.prdata[kxc_pkg::OFFER_SLOT_LSB +: 8] = s_ff.offer_slot;
               nxt_s.prdata[kxc_pkg::OFFER_TXN_LSB +: 8]  = s_ff.offer_txn;
            end

            kxc_pkg::REG_SUBTYPE: begin
               nxt_s.prdata[15:0] = kxc_pkg::SUBTYPE;
            end

            kxc_pkg::REG_TIMER: begin
               nxt_s.prdata[kxc_pkg::TMR_W-1:0] = s_ff.tmr;
               nxt_s.prdata[31]                 = s_ff.tmr_run;
            end

            default: begin
               nxt_s.pslverr = 1'b1;
            end
         endcase
      end

      // apb writes in the access phase
      if (apb_wr) begin
         case (paddr)
            kxc_pkg::REG_CTRL: begin
               if (pwdata[kxc_pkg::CTRL_ASK_BIT]) begin
                  if (pwdata[kxc_pkg::CTRL_WANT_LSB +: 8] <= kxc_pkg::SLOT_MAX) begin
                     nxt_s.wanted   = pwdata[kxc_pkg::CTRL_WANT_LSB +: 8];
                     nxt_s.ask_pend = 1'b1;
                  end else begin
                     set_bits[kxc_pkg::ST_REFUSED] = 1'b1;
                  end
               end
               // active changes only by commit of pending
               if (pwdata[kxc_pkg::CTRL_COMMIT_BIT] && (s_ff.pending != kxc_pkg::SLOT_NONE)) begin
                  nxt_s.active  = s_ff.pending;
                  nxt_s.pending = kxc_pkg::SLOT_NONE;
               end
            end

            kxc_pkg::REG_OUTCOME: begin
               if (pwdata[7:0] <= kxc_pkg::OC_MAX) begin
                  nxt_s.outcome = pwdata[7:0];
               end else begin
                  set_bits[kxc_pkg::ST_REFUSED] = 1'b1;
               end
            end

            kxc_pkg::REG_KEYSLOT: begin
               // pending takes slot or none only
               if ((pwdata[kxc_pkg::PEND_LSB +: 8] <= kxc_pkg::SLOT_MAX)
                   || (pwdata[kxc_pkg::PEND_LSB +: 8] == kxc_pkg::SLOT_NONE)) begin
                  nxt_s.pending = pwdata[kxc_pkg::PEND_LSB +: 8];
               end else begin
                  set_bits[kxc_pkg::ST_REFUSED] = 1'b1;
               end
            end

            kxc_pkg::REG_LAST_GOOD: begin
               nxt_s.last_good = pwdata[7:0];
            end

            kxc_pkg::REG_STATUS: begin
               clr_bits = pwdata[kxc_pkg::ST_W-1:0];
            end

            default: begin
            end
         endcase
      end

      if (s_ff.tmr_run) begin
         if (s_ff.tmr == '0) begin
            nxt_s.tmr_run                 = 1'b0;
            set_bits[kxc_pkg::ST_TIMEOUT] = 1'b1;
         end else begin
            nxt_s.tmr = s_ff.tmr - 26'h000_0001;
         end
      end

      // receive header capture
      if (rx_take) begin
         nxt_s.rx_type = v_type;
         nxt_s.rx_b1   = v_b1;
         nxt_s.rx_b2   = v_b2;
         if (rx_last) begin
            nxt_s.rx_cnt = 5'h00;
         end else if (s_ff.rx_cnt != 5'h1F) begin
            nxt_s.rx_cnt = s_ff.rx_cnt + 5'h01;
         end
      end

      case (s_ff.st)
         kxc_pkg::KXC_IDLE: begin
            if (rx_take && rx_last) begin
               case (v_type)
                  // key offer stores txn and slot
                  kxc_pkg::TYPE_OFFER: begin
                     nxt_s.offer_txn             = v_b1;
                     nxt_s.offer_slot            = v_b2;
                     nxt_s.tmr                   = TIMER_CYC[kxc_pkg::TMR_W-1:0] - 26'h000_0001;
                     nxt_s.tmr_run               = 1'b1;
                     set_bits[kxc_pkg::ST_OFFER] = 1'b1;
                  end

                  kxc_pkg::TYPE_NET_DONE: begin
                     nxt_s.tmr_run = 1'b0;
                     nxt_s.frame   = {kxc_pkg::TYPE_TERM_DONE, s_ff.offer_txn, oc, 136'h0};
                     if (prior_on) begin
                        nxt_s.frame[7:0] = s_ff.last_good;
                     end
                     nxt_s.len = kxc_pkg::LEN_HDR + (tag_on ? kxc_pkg::LEN_TAG : 5'h00)
                                 + (prior_on ? kxc_pkg::LEN_PRIOR : 5'h00);
                     set_bits[kxc_pkg::ST_DONE] = 1'b1;
                     if (tag_on) begin
                        nxt_s.mac_req = 1'b1;
                        nxt_s.st      = kxc_pkg::KXC_MAC;
                     end else begin
                        nxt_s.st      = kxc_pkg::KXC_LOAD;
                     end
                  end

                  kxc_pkg::TYPE_PROPOSE: begin
                     if (v_b2 <= kxc_pkg::SLOT_MAX) begin
                        nxt_s.frame = {kxc_pkg::TYPE_CONFIRM, v_b1, v_b2, 136'h0};
                        nxt_s.len   = kxc_pkg::LEN_HDR;
                        nxt_s.pending                 = v_b2;
                        set_bits[kxc_pkg::ST_CONFIRM] = 1'b1;
                        nxt_s.st                      = kxc_pkg::KXC_LOAD;
                     end else begin
                        set_bits[kxc_pkg::ST_REFUSED] = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (!rx_take && !ser_busy && s_ff.ask_pend) begin
               nxt_s.frame    = {kxc_pkg::TYPE_ASK, s_ff.wanted, 144'h0};
               nxt_s.len      = kxc_pkg::LEN_ASK;
               nxt_s.ask_pend = 1'b0;
               set_bits[kxc_pkg::ST_ASK] = 1'b1;
               nxt_s.st       = kxc_pkg::KXC_LOAD;
            end
         end

         kxc_pkg::KXC_MAC: begin
            if (mac_done) begin
               nxt_s.frame[135:8] = mac_tag;
               nxt_s.st           = kxc_pkg::KXC_LOAD;
            end
         end

         kxc_pkg::KXC_LOAD: begin
            nxt_s.st = kxc_pkg::KXC_IDLE;
         end
         default: begin
            nxt_s.st = kxc_pkg::KXC_IDLE;
         end
      endcase

      // set wins over clear
      nxt_s.sticky = (s_ff.sticky & ~clr_bits) | set_bits;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_ff            <= '0;
         s_ff.st         <= kxc_pkg::KXC_IDLE;
         s_ff.active     <= kxc_pkg::ACTIVE_RST;
         s_ff.pending    <= kxc_pkg::SLOT_NONE;
         s_ff.last_good  <= kxc_pkg::LAST_GOOD_RST;
         s_ff.outcome    <= kxc_pkg::OC_OK;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata       = s_ff.prdata;
   assign pslverr      = s_ff.pslverr;
   assign pready       = 1'b1;
   assign mac_req      = s_ff.mac_req;
   assign mac_key_slot = s_ff.offer_slot;
   assign mac_msg      = s_ff.frame;
   assign mac_len      = s_ff.len;

   kxc_ser #(
      .NB (kxc_pkg::FRAME_W / 8)
   ) u_ser (
      .mclk     (mclk),
      .resetn   (resetn),
      .load     (s_ff.st == kxc_pkg::KXC_LOAD),
      .frame    (s_ff.frame),
      .len      (s_ff.len),
      .busy     (ser_busy),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .tx_ready (tx_ready)
   );
endmodule : kxc_codec
`default_nettype wire

// ### rtl/kxc_pkg.sv
// What this block does
// - terminal done message: type, txn tag, outcome, optional tag, optional prior tag
// - terminal done message type code is 0x04
// - terminal done echoes the txn tag of the key offer
// - outcome codes 0x00 to 0x05; other values reserved
// - integrity tag omitted for outcome 0x01 or 0x03, present otherwise
// - tag is truncated keyed hash of message with tag zeroed, offer slot key
// - prior txn tag holds last good txn, only when outcome is 0x04
// - key slot indices in rekey messages lie in 0x00 to 0x07
// - rekey propose carries type 0x06, txn tag, proposed slot
// - network puts the proposed slot in the rekey propose
// - terminal answers rekey propose with rekey confirm, type 0x07
// - rekey confirm echoes propose txn tag and repeats proposed slot
// - confirm slot names the slot the network proposed
// - block issues no commands and takes no indications from others
// - active slot never changed by generic attribute update
// - active slot attribute id 0x00 holds 0x00 to 0x07
// - pending slot attribute id 0x01 holds 0x00 to 0x07 or 0xFF
// - reply wait timer runs 500 ms
// - protocol subtype is 0x0001
// - key offer recognised by type 0x01, gives slot and txn tag
// - network done recognised by type 0x03, triggers terminal done
package kxc_pkg;
   // message type codes
   localparam logic [7:0]  TYPE_OFFER    = 8'h01;
   localparam logic [7:0]  TYPE_NET_DONE = 8'h03;
   localparam logic [7:0]  TYPE_TERM_DONE = 8'h04;
   localparam logic [7:0]  TYPE_ASK      = 8'h05;
   localparam logic [7:0]  TYPE_PROPOSE  = 8'h06;
   localparam logic [7:0]  TYPE_CONFIRM  = 8'h07;
   // outcome codes
   localparam logic [7:0]  OC_OK         = 8'h00;
   localparam logic [7:0]  OC_MIC_FAIL   = 8'h01;
   localparam logic [7:0]  OC_NO_MK      = 8'h03;
   localparam logic [7:0]  OC_BAD_TXN    = 8'h04;
   localparam logic [7:0]  OC_MAX        = 8'h05;
   // key slot attributes
   localparam logic [7:0]  ATTR_ACTIVE_ID  = 8'h00;
   localparam logic [7:0]  ATTR_PENDING_ID = 8'h01;
   localparam logic [7:0]  SLOT_MAX      = 8'h07;
   localparam logic [7:0]  SLOT_NONE     = 8'hFF;
   localparam logic [7:0]  ACTIVE_RST    = 8'h00;
   localparam logic [15:0] SUBTYPE       = 16'h0001;
   // frame layout
   localparam int          FRAME_W       = 160;
   localparam int          LEN_W         = 5;
   localparam int          TAG_W         = 128;
   localparam logic [4:0]  LEN_HDR       = 5'h03;
   localparam logic [4:0]  LEN_TAG       = 5'h10;
   localparam logic [4:0]  LEN_PRIOR     = 5'h01;
   localparam logic [4:0]  LEN_ASK       = 5'h02;
   // reply wait timer
   localparam int          REPLY_WAIT_MS = 500;
   localparam int          CLK_HZ        = 125_000_000;
   localparam int          REPLY_WAIT_CYC = REPLY_WAIT_MS * (CLK_HZ / 1000);
   localparam int          TMR_W         = 26;
   // register offsets
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_OUTCOME   = 8'h04;
   localparam logic [7:0]  REG_KEYSLOT   = 8'h08;
   localparam logic [7:0]  REG_LAST_GOOD = 8'h0C;
   localparam logic [7:0]  REG_STATUS    = 8'h10;
   localparam logic [7:0]  REG_SUBTYPE   = 8'h14;
   localparam logic [7:0]  REG_TIMER     = 8'h18;
   // ctrl, keyslot and status register fields
   localparam int          CTRL_ASK_BIT    = 0;
   localparam int          CTRL_COMMIT_BIT = 1;
   localparam int          CTRL_WANT_LSB   = 8;
   localparam int          PEND_LSB        = 8;
   localparam int          OFFER_SLOT_LSB  = 8;
   localparam int          OFFER_TXN_LSB   = 16;
   // status bits
   localparam int          ST_OFFER   = 0;
   localparam int          ST_DONE    = 1;
   localparam int          ST_CONFIRM = 2;
   localparam int          ST_TIMEOUT = 3;
   localparam int          ST_REFUSED = 4;
   localparam int          ST_ASK     = 5;
   localparam int          ST_W       = 6;
   localparam logic [7:0]  LAST_GOOD_RST = 8'h00;

   typedef enum logic [1:0] {KXC_IDLE, KXC_MAC, KXC_LOAD} kxc_state_t;
endpackage : kxc_pkg

// ### rtl/kxc_ser.sv
`timescale 1ns/100ps
`default_nettype none
module kxc_ser #(
   parameter int NB = 20
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   // frame load
   input  wire logic                     load,
   input  wire logic [NB*8-1:0]          frame,
   input  wire logic [kxc_pkg::LEN_W-1:0] len,
   output logic                          busy,
   // byte stream out
   output logic                          tx_valid,
   output logic [7:0]                    tx_data,
   output logic                          tx_last,
   input  wire logic                     tx_ready
);
   typedef struct packed {
      logic [NB*8-1:0]          sh;
      logic [kxc_pkg::LEN_W-1:0] left;
   } kxc_ser_t;

   kxc_ser_t s_ff;
   kxc_ser_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (load) begin
         nxt_s.sh   = frame;
         nxt_s.left = len;
      end else if (tx_valid && tx_ready) begin
         nxt_s.sh   = {s_ff.sh[NB*8-9:0], 8'h00};
         nxt_s.left = s_ff.left - 5'h01;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign busy     = (s_ff.left != '0);
   assign tx_valid = busy;
   assign tx_data  = s_ff.sh[NB*8-1 -: 8];
   assign tx_last  = (s_ff.left == 5'h01);
endmodule : kxc_ser
`default_nettype wire

// ### sim/kxc_codec_properties.sv
`timescale 1ns/100ps
`default_nettype none
module kxc_codec_props #(
   parameter int TIMER_CYC = 50
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready,
   // hash
   input wire logic mac_req,
   input wire logic [7:0] mac_key_slot,
   input wire logic [kxc_pkg::FRAME_W-1:0] mac_msg,
   input wire logic [kxc_pkg::LEN_W-1:0] mac_len,
   input wire logic mac_done,
   input wire logic [kxc_pkg::TAG_W-1:0] mac_tag
);
   logic first_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // first byte of each frame
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) first_ff <= 1'b1;
      else if (tx_valid && tx_ready) first_ff <= tx_last;
   end
   tx_type_a : assert property (tx_valid && first_ff |-> tx_data inside {8'h04, 8'h05, 8'h07})
      else $error("bad message type byte");
   mac_pulse_a : assert property (mac_req |=> !mac_req)
      else $error("hash request too long");
   mac_zero_a : assert property (mac_req |-> mac_msg[135:8] == 128'h0 && mac_msg[159:152] == 8'h04)
      else $error("hashed message not zeroed");
   mac_outcome_a : assert property (mac_req |-> !(mac_msg[143:136] inside {8'h01, 8'h03}))
      else $error("hash asked for tagless outcome");
   mac_len_a : assert property (mac_req |-> mac_len == ((mac_msg[143:136] == 8'h04) ? 5'h14 : 5'h13))
      else $error("hashed length wrong");
   tag_send_a : assert property (mac_done |-> ##[1:6] tx_valid)
      else $error("frame not sent after hash");
   tx_hold_a : assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("byte changed while stalled");
   rx_block_a : assert property (tx_valid |-> !rx_ready)
      else $error("receiving while replying");
   cover property (mac_req);
   cover property (tx_valid && tx_ready && tx_last);
   cover property (psel && penable && pslverr);
endmodule : kxc_codec_props
bind kxc_codec kxc_codec_props #(.TIMER_CYC(TIMER_CYC)) props_i (.mclk(mclk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .mac_req(mac_req),
   .mac_key_slot(mac_key_slot), .mac_msg(mac_msg), .mac_len(mac_len), .mac_done(mac_done), .mac_tag(mac_tag));
`default_nettype wire

// ### sim/kxc_peer.sv
`timescale 1ns/100ps
`default_nettype none
module kxc_peer (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // hash engine
   input wire logic mac_req,
   input wire logic [7:0] mac_key_slot,
   input wire logic [kxc_pkg::FRAME_W-1:0] mac_msg,
   input wire logic [kxc_pkg::LEN_W-1:0] mac_len,
   output logic mac_done,
   output logic [kxc_pkg::TAG_W-1:0] mac_tag,
   // byte sink
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [8:0] q[$];
   logic [31:0] word;
   int wait_n;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mac_done <= 1'b0;
         mac_tag <= '0;
         tx_ready <= 1'b0;
         wait_n <= 0;
      end else begin
         tx_ready <= ($urandom_range(0, 3) != 0);
         if (tx_valid && tx_ready) q.push_back({tx_last, tx_data});
         mac_done <= !mac_req && (wait_n == 1);
         mac_tag <= (!mac_req && (wait_n == 1)) ? {4{word}} : ~mac_tag;
         if (mac_req) begin
            word <= {mac_key_slot, mac_msg[151:136], 3'h0, mac_len};
            wait_n <= $urandom_range(1, 5);
         end else if (wait_n > 0) wait_n <= wait_n - 1;
      end
   end
endmodule : kxc_peer
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, er;
   logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, mac_req, mac_done;
   logic [7:0] paddr, rx_data, tx_data, mac_key_slot, t, s, lg, oc, eo, w;
   logic [31:0] pwdata, prdata, rd;
   logic [kxc_pkg::FRAME_W-1:0] mac_msg;
   logic [kxc_pkg::LEN_W-1:0] mac_len;
   logic [kxc_pkg::TAG_W-1:0] mac_tag;
   logic [8:0] exp_q[$];
   int n_fail, samples_checked;
   kxc_codec #(.TIMER_CYC(50)) uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .mac_req(mac_req),
      .mac_key_slot(mac_key_slot), .mac_msg(mac_msg), .mac_len(mac_len), .mac_done(mac_done), .mac_tag(mac_tag));
   kxc_peer peer (.mclk(mclk), .resetn(resetn), .mac_req(mac_req), .mac_key_slot(mac_key_slot),
      .mac_msg(mac_msg), .mac_len(mac_len), .mac_done(mac_done), .mac_tag(mac_tag), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task rx_msg(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      logic [7:0] b[3];
      b = '{b0, b1, b2};
      for (int i = 0; i < 3; i++) begin
         rx_valid <= 1'b1;
         rx_data <= b[i];
         rx_last <= (i == 2);
         @(posedge mclk);
         while (rx_ready !== 1'b1) @(posedge mclk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~b2;
      @(posedge mclk);
   endtask : rx_msg
   task ex(input logic [7:0] v);
      exp_q.push_back({1'b0, v});
   endtask : ex
   task frame_chk;
      int n;
      n = 0;
      if (exp_q.size() > 0) exp_q[exp_q.size()-1][8] = 1'b1;
      while ((exp_q.size() == 0 || peer.q.size() < exp_q.size()) && n < 500) begin
         @(posedge mclk);
         n = n + ((exp_q.size() == 0) ? 13 : 1);
      end
      chk("frame length", exp_q.size(), peer.q.size());
      foreach (exp_q[i]) if (i < peer.q.size()) chk("frame byte", {23'h0, exp_q[i]}, {23'h0, peer.q[i]});
      exp_q.delete();
      peer.q.delete();
   endtask : frame_chk
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      $display("mismatch watchdog expected end seen timeout");
      summarize();
   end
   initial begin
      {psel, penable, pwrite, rx_valid, rx_last, resetn} = '0;
      {paddr, pwdata, rx_data} = '0;
      n_fail = 0;
      samples_checked = 0;
      void'($urandom(32'h5901AE4D));
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      apb(1'b0, kxc_pkg::REG_SUBTYPE, 32'h0);
      chk("subtype", 32'h00000001, rd);
      apb(1'b0, kxc_pkg::REG_KEYSLOT, 32'h0);
      chk("keyslot reset", 32'h0000FF00, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      apb(1'b1, kxc_pkg::REG_OUTCOME, 32'h6);
      apb(1'b0, kxc_pkg::REG_OUTCOME, 32'h0);
      chk("reserved outcome", 32'h0, rd);
      $display("test registers done");
      for (int k = 0; k < 7; k++) begin
         t = 8'($urandom);
         s = 8'($urandom_range(0, 7));
         lg = 8'($urandom);
         oc = (k == 6) ? 8'h00 : 8'(k);
         eo = (k == 6) ? 8'h04 : oc;
         apb(1'b1, kxc_pkg::REG_OUTCOME, {24'h0, oc});
         apb(1'b1, kxc_pkg::REG_LAST_GOOD, {24'h0, lg});
         rx_msg(8'h01, t, s);
         rx_msg(8'h03, (k == 6) ? t + 8'h01 : t, 8'h00);
         ex(8'h04);
         ex(t);
         ex(eo);
         if (eo != 8'h01 && eo != 8'h03) repeat (4) begin
            ex(s);
            ex(t);
            ex(eo);
            ex((eo == 8'h04) ? 8'h14 : 8'h13);
         end
         if (eo == 8'h04) ex(lg);
         frame_chk();
      end
      $display("test terminal done finished");
      t = 8'($urandom);
      s = 8'($urandom_range(0, 7));
      rx_msg(8'h06, t, s);
      ex(8'h07);
      ex(t);
      ex(s);
      frame_chk();
      apb(1'b0, kxc_pkg::REG_KEYSLOT, 32'h0);
      chk("pending slot", {16'h0, s, 8'h00}, rd);
      apb(1'b1, kxc_pkg::REG_CTRL, 32'h2);
      apb(1'b0, kxc_pkg::REG_KEYSLOT, 32'h0);
      chk("commit slot", {16'h0, 8'hFF, s}, rd);
      w = 8'($urandom_range(0, 7));
      apb(1'b1, kxc_pkg::REG_CTRL, {16'h0, w, 8'h01});
      ex(8'h05);
      ex(w);
      frame_chk();
      $display("test rekey done");
      apb(1'b1, kxc_pkg::REG_STATUS, 32'hFF);
      rx_msg(8'h06, t, 8'h08);
      apb(1'b1, kxc_pkg::REG_CTRL, 32'h0901);
      apb(1'b1, kxc_pkg::REG_KEYSLOT, 32'h0800);
      frame_chk();
      apb(1'b0, kxc_pkg::REG_STATUS, 32'h0);
      chk("refused flag", 32'h1, {31'h0, rd[4]});
      apb(1'b0, kxc_pkg::REG_KEYSLOT, 32'h0);
      chk("refused slots", {16'h0, 8'hFF, s}, rd);
      apb(1'b1, kxc_pkg::REG_STATUS, 32'hFF);
      rx_msg(8'h01, t, s);
      repeat (60) @(posedge mclk);
      apb(1'b0, kxc_pkg::REG_STATUS, 32'h0);
      chk("timer expired", 32'h1, {31'h0, rd[3]});
      apb(1'b0, kxc_pkg::REG_TIMER, 32'h0);
      chk("timer stopped", 32'h0, rd);
      $display("test refusals and timer done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
